/* File: design/btg_gain_ctrl.sv */
`timescale 1ns/1ps
module btg_gain_ctrl
  import btg_pkg::*;
#(
  parameter int LVL_W    = 12,
  parameter int SMP_W    = 16,
  parameter int TMR_W    = 27,
  parameter int ATK_BASE = ATK_BASE_CYC,
  parameter int ATK_STEP = ATK_STEP_CYC,
  parameter int REL_BASE = REL_BASE_CYC,
  parameter int REL_STEP = REL_STEP_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  input  wire logic              addr_strap,
  output logic                   sda_out,
  output logic                   sda_oe,
  input  wire logic [7:0]        vbat_level,
  input  wire logic [LVL_W-1:0]  boost_limit,
  input  wire logic [LVL_W-1:0]  out_level,
  input  wire logic [SMP_W-1:0]  analog_sample,
  input  wire logic [SMP_W-1:0]  digital_sample,
  output logic      [SMP_W-1:0]  amp_sample,
  output logic      [GAIN_W-1:0] amp_gain,
  output logic      [SLEW_W-1:0] switching_slew_control
);
  if (LVL_W > DROP_W || REL_BASE + 15 * REL_STEP >= 2 ** (TMR_W - 1)
      || ATK_BASE < 1 || REL_BASE < 1) begin : g_bad_params
    $error("btg_gain_ctrl: level width or timer width cannot serve the step times");
  end

  btg_reg_if bus ();

  btg_i2c_slave u_i2c (
    .clk        (clk),
    .rst_b      (rst_b),
    .scl_in     (scl_in),
    .sda_in     (sda_in),
    .addr_strap (addr_strap),
    .sda_oe     (sda_oe),
    .bus        (bus)
  );

  // Open-drain: the pin is only ever pulled low
  assign sda_out = 1'b0;

  function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] r);
    return wr && a == r;
  endfunction

  logic [7:0]        infl_q, slope_q;
  logic [ATK_W-1:0]  atk_q;
  logic [REL_W-1:0]  rel_q;
  logic [GAIN_W-1:0] fixed_q, agc_gain_q, gain_d;
  logic [CTRL_W-1:0] ctrl_q;
  logic [SMP_W-1:0]  amp_sample_q;
  logic [TMR_W-1:0]  tmr_q, tmr_d, atk_cyc_w, rel_cyc_w, ivl_w;
  btg_agc_e          agc_st_q, agc_st_d;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      infl_q  <= RST_INFLECTION;
      slope_q <= RST_SLOPE;
      atk_q   <= RST_ATTACK;
      rel_q   <= RST_RELEASE;
      fixed_q <= RST_FIXED_GAIN;
      ctrl_q  <= RST_OUT_CTRL;
    end else begin
      if (wr_hit(bus.wr, bus.addr, REG_INFLECTION)) infl_q <= bus.wdata;
      if (wr_hit(bus.wr, bus.addr, REG_SLOPE)) slope_q <= bus.wdata;
      if (wr_hit(bus.wr, bus.addr, REG_ATTACK)) atk_q <= bus.wdata[ATK_W-1:0];
      if (wr_hit(bus.wr, bus.addr, REG_RELEASE)) rel_q <= bus.wdata[REL_W-1:0];
      if (wr_hit(bus.wr, bus.addr, REG_FIXED_GAIN)) fixed_q <= bus.wdata[GAIN_W-1:0];
      if (wr_hit(bus.wr, bus.addr, REG_OUT_CTRL)) ctrl_q <= bus.wdata[CTRL_W-1:0];
    end
  end

  // Unmapped offsets read zero
  assign bus.rdata =
    (bus.addr == REG_INFLECTION) ? infl_q :
    (bus.addr == REG_SLOPE)      ? slope_q :
    (bus.addr == REG_ATTACK)     ? {{(8 - ATK_W){1'b0}}, atk_q} :
    (bus.addr == REG_RELEASE)    ? {{(8 - REL_W){1'b0}}, rel_q} :
    (bus.addr == REG_FIXED_GAIN) ? {{(8 - GAIN_W){1'b0}}, fixed_q} :
    (bus.addr == REG_OUT_CTRL)   ? {{(8 - CTRL_W){1'b0}}, ctrl_q} :
    (bus.addr == REG_AGC_STATUS) ? {1'b0, agc_st_q, agc_gain_q} : 8'h00;

  wire src_digital_w = ctrl_q[CTRL_SRC_BIT];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      amp_sample_q <= '0;
    end else begin
      amp_sample_q <= src_digital_w ? digital_sample : analog_sample;
    end
  end

  assign amp_sample             = amp_sample_q;
  assign amp_gain               = agc_gain_q;
  assign switching_slew_control = ctrl_q[SLEW_W-1:0];

  // Peak limit from battery, inflection point and slope
  logic [7:0]        vdiff_w;
  logic [8:0]        slope_eff_w;
  logic [DROP_W-1:0] drop_w, boost_full_w;
  logic [LVL_W-1:0]  limit_w;
  wire               below_w = vbat_level < infl_q;

  assign vdiff_w      = infl_q - vbat_level;
  assign slope_eff_w  = {1'b0, slope_q} + SLOPE_BASE;
  assign drop_w       = (DROP_W'(vdiff_w) * DROP_W'(slope_eff_w) * DROP_W'(SLOPE_NUM))
                        >> SLOPE_SHIFT;
  assign boost_full_w = DROP_W'(boost_limit);
  assign limit_w      = !below_w ? boost_limit :
                        (drop_w >= boost_full_w) ? '0 : LVL_W'(boost_full_w - drop_w);

  // Only the output level decides; battery acts through the limit alone
  wire over_w  = out_level > limit_w;
  wire under_w = out_level < limit_w;

  assign atk_cyc_w = TMR_W'(ATK_BASE + int'(atk_q) * ATK_STEP);
  assign rel_cyc_w = TMR_W'(REL_BASE + int'(rel_q) * REL_STEP);

  assign agc_st_d = over_w ? AGC_ATTACK :
                    (under_w && agc_gain_q < fixed_q) ? AGC_RELEASE : AGC_HOLD;

  wire enter_w = agc_st_d != agc_st_q;
  wire tick_w  = tmr_q == '0;
  wire step_w  = !enter_w && tick_w && agc_st_q != AGC_HOLD;

  // A fresh interval starts on every change of direction
  assign ivl_w = (agc_st_d == AGC_ATTACK) ? atk_cyc_w : rel_cyc_w;
  assign tmr_d = (enter_w || tick_w) ? ivl_w - 1'b1 : tmr_q - 1'b1;

  // A lowered fixed gain pulls the working gain down at once
  assign gain_d = (agc_gain_q > fixed_q) ? fixed_q :
                  (step_w && agc_st_q == AGC_ATTACK && agc_gain_q != GAIN_MIN)
                    ? agc_gain_q - 1'b1 :
                  (step_w && agc_st_q == AGC_RELEASE)
                    ? agc_gain_q + 1'b1 : agc_gain_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      agc_st_q   <= AGC_HOLD;
      tmr_q      <= '0;
      agc_gain_q <= RST_FIXED_GAIN;
    end else begin
      agc_st_q   <= agc_st_d;
      tmr_q      <= tmr_d;
      agc_gain_q <= gain_d;
    end
  end

  a_gain_under_fixed: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> agc_gain_q <= $past(fixed_q))
    else $error("gain rose above fixed gain");
  a_gain_one_step: assert property (@(posedge clk) disable iff (!rst_b)
    (agc_gain_q <= fixed_q) |=> (agc_gain_q == $past(agc_gain_q)
      || agc_gain_q == $past(agc_gain_q) + 1'b1 || agc_gain_q == $past(agc_gain_q) - 1'b1))
    else $error("gain moved by more than one step");
  a_no_cut_under: assert property (@(posedge clk) disable iff (!rst_b)
    (!over_w && agc_gain_q <= fixed_q) |=> agc_gain_q >= $past(agc_gain_q))
    else $error("gain cut while output under limit");
  a_no_rise_over: assert property (@(posedge clk) disable iff (!rst_b)
    over_w |=> agc_gain_q <= $past(agc_gain_q))
    else $error("gain rose while output over limit");
  a_attack_cut: assert property (@(posedge clk) disable iff (!rst_b)
    (agc_st_q == AGC_ATTACK && agc_st_d == AGC_ATTACK && tick_w && agc_gain_q != GAIN_MIN
      && agc_gain_q <= fixed_q) |=> agc_gain_q == $past(agc_gain_q) - 1'b1)
    else $error("attack interval elapsed without a cut");
  a_release_rise: assert property (@(posedge clk) disable iff (!rst_b)
    (agc_st_q == AGC_RELEASE && agc_st_d == AGC_RELEASE && tick_w)
      |=> agc_gain_q == $past(agc_gain_q) + 1'b1)
    else $error("release interval elapsed without a rise");
  a_attack_load: assert property (@(posedge clk) disable iff (!rst_b)
    (agc_st_q != AGC_ATTACK && agc_st_d == AGC_ATTACK)
      |=> tmr_q == $past(atk_cyc_w) - 1'b1 ##1 tmr_q == $past(tmr_q) - 1'b1)
    else $error("attack interval not loaded");
  a_release_load: assert property (@(posedge clk) disable iff (!rst_b)
    (agc_st_q != AGC_RELEASE && agc_st_d == AGC_RELEASE) |=> tmr_q == $past(rel_cyc_w) - 1'b1)
    else $error("release interval not loaded");
  a_limit_boost: assert property (@(posedge clk) disable iff (!rst_b)
    !below_w |-> limit_w == boost_limit)
    else $error("limit not from boost above inflection");
  a_limit_floor: assert property (@(posedge clk) disable iff (!rst_b)
    below_w |-> limit_w <= boost_limit)
    else $error("limit above boost level below inflection");
  a_limit_slope: assert property (@(posedge clk) disable iff (!rst_b)
    (below_w && $stable(vbat_level) && $stable(boost_limit) && slope_q > $past(slope_q))
      |-> limit_w <= $past(limit_w))
    else $error("steeper slope raised the limit");
  a_infl_write: assert property (@(posedge clk) disable iff (!rst_b)
    (bus.wr && bus.addr == REG_INFLECTION) |=> infl_q == $past(bus.wdata))
    else $error("inflection write lost");
  a_src_single: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> amp_sample == ($past(src_digital_w) ? $past(digital_sample) : $past(analog_sample)))
    else $error("amplifier source not a single input");
  a_slew_write: assert property (@(posedge clk) disable iff (!rst_b)
    (bus.wr && bus.addr == REG_OUT_CTRL)
      |=> switching_slew_control == $past(bus.wdata[SLEW_W-1:0]))
    else $error("slew code not applied");

  c_attack_step: cover property (@(posedge clk) disable iff (!rst_b)
    agc_st_q == AGC_ATTACK && step_w);
  c_release_step: cover property (@(posedge clk) disable iff (!rst_b)
    agc_st_q == AGC_RELEASE && step_w);
  c_below_infl_over: cover property (@(posedge clk) disable iff (!rst_b) below_w && over_w);
endmodule

/* File: design/btg_i2c_slave.sv */
`timescale 1ns/1ps
module btg_i2c_slave
  import btg_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic addr_strap,
  output logic      sda_oe,
  btg_reg_if.i2c    bus
);
  logic [1:0] scl_s_q, sda_s_q, strap_s_q;
  logic       scl_d1_q, sda_d1_q, oe_q, wr_q, rw_ok;
  logic [3:0] bit_q;
  logic [7:0] sh_q, ptr_q;
  btg_i2c_e   st_q, nxt_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_s_q   <= 2'h3;
      sda_s_q   <= 2'h3;
      strap_s_q <= 2'h0;
      scl_d1_q  <= 1'b1;
      sda_d1_q  <= 1'b1;
    end else begin
      scl_s_q   <= {scl_s_q[0], scl_in};
      sda_s_q   <= {sda_s_q[0], sda_in};
      strap_s_q <= {strap_s_q[0], addr_strap};
      scl_d1_q  <= scl_s_q[1];
      sda_d1_q  <= sda_s_q[1];
    end
  end

  wire       scl_w    = scl_s_q[1];
  wire       sda_w    = sda_s_q[1];
  wire       rise_w   = scl_w & ~scl_d1_q;
  wire       fall_w   = ~scl_w & scl_d1_q;
  wire       start_w  = scl_w & scl_d1_q & sda_d1_q & ~sda_w;
  wire       stop_w   = scl_w & scl_d1_q & ~sda_d1_q & sda_w;
  wire [6:0] my_addr  = DEV_ADDR_BASE | {6'h00, strap_s_q[1]};
  wire       byte_end = fall_w && bit_q == BYTE_BITS;

  assign rw_ok     = sh_q[7:1] == my_addr;
  assign sda_oe    = oe_q;
  assign bus.wr    = wr_q;
  assign bus.addr  = ptr_q;
  assign bus.wdata = sh_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q  <= I2C_IDLE;
      nxt_q <= I2C_IDLE;
      bit_q <= 4'h0;
      sh_q  <= 8'h00;
      ptr_q <= 8'h00;
      oe_q  <= 1'b0;
      wr_q  <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      // Pointer moves after the write strobe so the strobe sees its own offset
      if (wr_q) begin
        ptr_q <= ptr_q + 8'h01;
      end
      if (start_w) begin
        st_q  <= I2C_ADDR;
        bit_q <= 4'h0;
        oe_q  <= 1'b0;
      end else if (stop_w) begin
        st_q <= I2C_IDLE;
        oe_q <= 1'b0;
      end else begin
        unique case (st_q)
          I2C_IDLE: begin
          end
          I2C_ADDR, I2C_PTR, I2C_WDATA: begin
            if (rise_w) begin
              sh_q  <= {sh_q[6:0], sda_w};
              bit_q <= bit_q + 4'h1;
            end else if (byte_end) begin
              st_q  <= I2C_ACK;
              oe_q  <= 1'b1;
              bit_q <= 4'h0;
              if (st_q == I2C_ADDR) begin
                nxt_q <= sh_q[0] ? I2C_RDATA : I2C_PTR;
                if (!rw_ok) begin
                  st_q <= I2C_IDLE;
                  oe_q <= 1'b0;
                end
              end else if (st_q == I2C_PTR) begin
                ptr_q <= sh_q;
                nxt_q <= I2C_WDATA;
              end else begin
                wr_q  <= 1'b1;
                nxt_q <= I2C_WDATA;
              end
            end
          end
          I2C_ACK: begin
            if (fall_w) begin
              st_q <= nxt_q;
              if (nxt_q == I2C_RDATA) begin
                sh_q  <= bus.rdata;
                oe_q  <= ~bus.rdata[7];
                ptr_q <= ptr_q + 8'h01;
              end else begin
                oe_q <= 1'b0;
              end
            end
          end
          I2C_RDATA: begin
            if (rise_w) begin
              bit_q <= bit_q + 4'h1;
            end else if (byte_end) begin
              oe_q  <= 1'b0;
              bit_q <= 4'h0;
              st_q  <= I2C_RACK;
            end else if (fall_w) begin
              sh_q <= {sh_q[6:0], 1'b0};
              oe_q <= ~sh_q[6];
            end
          end
          I2C_RACK: begin
            // Master ack fetches the next byte, nack ends the read
            if (rise_w) begin
              st_q  <= sda_w ? I2C_IDLE : I2C_ACK;
              nxt_q <= I2C_RDATA;
            end
          end
          default: st_q <= I2C_IDLE;
        endcase
      end
    end
  end

  a_oe_acks_addr: assert property (@(posedge clk) disable iff (!rst_b)
    (byte_end && st_q == I2C_ADDR && !start_w && !stop_w) |=> oe_q == $past(rw_ok))
    else $error("address ack does not match address compare");
  c_reg_write: cover property (@(posedge clk) disable iff (!rst_b) wr_q);
endmodule

/* File: design/btg_pkg.sv */
package btg_pkg;
  // Device address; the strap pin supplies the low bit
  localparam logic [6:0] DEV_ADDR_BASE  = 7'h40;
  localparam logic [3:0] BYTE_BITS      = 4'h8;

  // Register offsets
  localparam logic [7:0] REG_INFLECTION = 8'h0b;
  localparam logic [7:0] REG_SLOPE      = 8'h0c;
  localparam logic [7:0] REG_ATTACK     = 8'h0e;
  localparam logic [7:0] REG_RELEASE    = 8'h0f;
  localparam logic [7:0] REG_FIXED_GAIN = 8'h10;
  localparam logic [7:0] REG_OUT_CTRL   = 8'h11;
  localparam logic [7:0] REG_AGC_STATUS = 8'h12;

  // Field widths and positions
  localparam int GAIN_W       = 5;
  localparam int SLEW_W       = 3;
  localparam int ATK_W        = 3;
  localparam int REL_W        = 4;
  localparam int CTRL_W       = 4;
  localparam int CTRL_SRC_BIT = 3;

  // Reset values and gain floor
  localparam logic [7:0]        RST_INFLECTION = 8'h80;
  localparam logic [7:0]        RST_SLOPE      = 8'h00;
  localparam logic [ATK_W-1:0]  RST_ATTACK     = 3'h0;
  localparam logic [REL_W-1:0]  RST_RELEASE    = 4'h0;
  localparam logic [GAIN_W-1:0] RST_FIXED_GAIN = 5'h07;
  localparam logic [CTRL_W-1:0] RST_OUT_CTRL   = 4'h0;
  localparam logic [GAIN_W-1:0] GAIN_MIN       = 5'h00;

  // Step timing
  localparam int CLK_HZ       = 25000000;
  localparam int CYC_PER_US   = CLK_HZ / 1000000;
  localparam int CYC_PER_MS   = CLK_HZ / 1000;
  localparam int ATK_BASE_US  = 20;
  localparam int ATK_STEP_US  = 350;
  localparam int REL_BASE_MS  = 50;
  localparam int REL_STEP_MS  = 105;
  localparam int ATK_BASE_CYC = ATK_BASE_US * CYC_PER_US;
  localparam int ATK_STEP_CYC = ATK_STEP_US * CYC_PER_US;
  localparam int REL_BASE_CYC = REL_BASE_MS * CYC_PER_MS;
  localparam int REL_STEP_CYC = REL_STEP_MS * CYC_PER_MS;

  // Slope: code 0 is 1.2 V/V, LSB 37.3 mV/V; 19/512 approximates 0.0373
  localparam logic [8:0] SLOPE_BASE  = 9'h020;
  localparam int         SLOPE_NUM   = 19;
  localparam int         SLOPE_SHIFT = 9;
  localparam int         DROP_W      = 22;

  typedef enum logic [1:0] {
    AGC_HOLD    = 2'b00,
    AGC_ATTACK  = 2'b01,
    AGC_RELEASE = 2'b10
  } btg_agc_e;

  typedef enum logic [2:0] {
    I2C_IDLE  = 3'b000,
    I2C_ADDR  = 3'b001,
    I2C_PTR   = 3'b010,
    I2C_WDATA = 3'b011,
    I2C_ACK   = 3'b100,
    I2C_RDATA = 3'b101,
    I2C_RACK  = 3'b110
  } btg_i2c_e;
endpackage

/* File: design/btg_reg_if.sv */
`timescale 1ns/1ps
interface btg_reg_if;
  logic       wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport i2c  (output wr, addr, wdata, input rdata);
  modport regs (input wr, addr, wdata, output rdata);
endinterface

/* File: verif/btg_host_model.sv */
`timescale 1ns/1ps
module btg_host_model (
  input  wire logic clk,
  input  wire logic sda_oe,
  output logic      scl_in,
  output logic      sda_in
);
  logic       host_low;
  logic [6:0] dev7;

  // Pull-up: the line only goes low while a party pulls it
  assign sda_in = ~(host_low | sda_oe);

  initial begin
    scl_in   = 1'b1;
    host_low = 1'b0;
    dev7     = 7'h40;
  end

  // Twice the minimum phase the slave needs
  task automatic half();
    repeat (8) @(negedge clk);
  endtask

  task automatic start_cond();
    host_low = 1'b0;
    half();
    scl_in = 1'b1;
    half();
    host_low = 1'b1;
    half();
    scl_in = 1'b0;
  endtask

  task automatic stop_cond();
    repeat (2) @(negedge clk);
    host_low = 1'b1;
    half();
    scl_in = 1'b1;
    half();
    host_low = 1'b0;
    half();
  endtask

  // Data changes a little after the clock fall, never at it
  task automatic bit_io(input logic b, output logic r);
    repeat (2) @(negedge clk);
    host_low = ~b;
    half();
    scl_in = 1'b1;
    half();
    r = sda_in;
    scl_in = 1'b0;
  endtask

  task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                         output logic ack_seen);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(ack_in, r);
    ack_seen = ~r;
  endtask

  task automatic reg_write(input logic [7:0] off, input logic [7:0] val, output logic ok);
    logic [7:0] q;
    logic       a0, a1, a2;
    start_cond();
    byte_io({dev7, 1'b0}, 1'b1, q, a0);
    byte_io(off, 1'b1, q, a1);
    byte_io(val, 1'b1, q, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask

  // Single-byte read: master ends with a not-acknowledge
  task automatic reg_read(input logic [7:0] off, output logic [7:0] val, output logic ok);
    logic [7:0] q;
    logic       a0, a1, a2, a3;
    start_cond();
    byte_io({dev7, 1'b0}, 1'b1, q, a0);
    byte_io(off, 1'b1, q, a1);
    start_cond();
    byte_io({dev7, 1'b1}, 1'b1, q, a2);
    byte_io(8'hff, 1'b1, val, a3);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
endmodule

/* File: verif/tb_btg_gain_ctrl.sv */
`timescale 1ns/1ps
module tb_btg_gain_ctrl;
  import btg_pkg::*;
  typedef struct packed {
    logic [3:0] ctrl;
    logic [4:0] gain;
  } btg_row_s;

  logic        clk, rst_b, scl_in, sda_in, sda_out, sda_oe, ok;
  logic [7:0]  vbat_level, rd;
  logic [11:0] boost_limit, out_level;
  logic [15:0] analog_sample, digital_sample, amp_sample, exp_smp;
  logic [4:0]  amp_gain, g;
  logic [2:0]  switching_slew_control;
  int          err_total, n_tests, cyc;
  btg_row_s    rows [8] = '{'{4'h0, 5'h00}, '{4'h9, 5'h1f}, '{4'h2, 5'h05}, '{4'hb, 5'h0c},
                            '{4'h4, 5'h01}, '{4'hd, 5'h18}, '{4'h6, 5'h1e}, '{4'hf, 5'h07}};

  // Short step intervals: attack code 2 gives 10 cycles, release code 1 gives 13
  btg_gain_ctrl #(.ATK_BASE(4), .ATK_STEP(3), .REL_BASE(8), .REL_STEP(5)) uut (
    .clk(clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in), .addr_strap(1'b0),
    .sda_out(sda_out), .sda_oe(sda_oe), .vbat_level(vbat_level), .boost_limit(boost_limit),
    .out_level(out_level), .analog_sample(analog_sample), .digital_sample(digital_sample),
    .amp_sample(amp_sample), .amp_gain(amp_gain),
    .switching_slew_control(switching_slew_control));

  btg_host_model host (.clk(clk), .sda_oe(sda_oe), .scl_in(scl_in), .sda_in(sda_in));

  initial clk = 1'b0;
  always #20 clk = ~clk;

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("Checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] off, input logic [7:0] val);
    host.reg_write(off, val, ok);
    check("write ack", {15'h0, ok}, 16'h0001);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] off, input logic [7:0] exp);
    host.reg_read(off, rd, ok);
    check(what, {7'h0, ok, rd}, {8'h01, exp});
  endtask

  // Cycles until the working gain moves, bounded
  task automatic wait_step();
    g = amp_gain;
    cyc = 0;
    while (amp_gain === g && cyc < 3000) begin
      @(negedge clk);
      cyc++;
    end
  endtask

  // New battery and level together, then one attack step later
  task automatic probe(input string what, input logic [7:0] vb, input logic [11:0] lvl,
                       input logic drop);
    @(negedge clk);
    g = amp_gain;
    vbat_level = vb;
    out_level = lvl;
    repeat (14) @(negedge clk);
    check(what, {11'h0, amp_gain}, {11'h0, g - {4'h0, drop}});
  endtask

  initial begin
    #3_000_000;
    err_total++;
    final_report();
  end

  initial begin
    rst_b = 1'b0;
    vbat_level = 8'hff;
    boost_limit = 12'd100;
    out_level = 12'd0;
    analog_sample = 16'h1a00;
    digital_sample = 16'hd100;
    repeat (4) @(negedge clk);
    check("reset gain", {11'h0, amp_gain}, {11'h0, RST_FIXED_GAIN});
    check("reset slew", {13'h0, switching_slew_control}, 16'h0000);
    check("reset sda", {15'h0, sda_oe}, 16'h0000);
    check("reset sample", amp_sample, 16'h0000);
    check("sda drive", {15'h0, sda_out}, 16'h0000);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    rd_chk("inflection", REG_INFLECTION, RST_INFLECTION);
    rd_chk("slope", REG_SLOPE, RST_SLOPE);
    rd_chk("attack", REG_ATTACK, {5'h0, RST_ATTACK});
    rd_chk("release", REG_RELEASE, {4'h0, RST_RELEASE});
    rd_chk("unmapped", 8'h20, 8'h00);
    foreach (rows[i]) begin
      analog_sample = 16'h1a00 + 16'(i);
      digital_sample = 16'hd100 + 16'(i);
      wr(REG_OUT_CTRL, {4'h0, rows[i].ctrl});
      wr(REG_FIXED_GAIN, {3'h0, rows[i].gain});
      repeat (400) @(negedge clk);
      check("slew", {13'h0, switching_slew_control}, {13'h0, rows[i].ctrl[2:0]});
      exp_smp = rows[i].ctrl[CTRL_SRC_BIT] ? digital_sample : analog_sample;
      check("source", amp_sample, exp_smp);
      check("gain", {11'h0, amp_gain}, {11'h0, rows[i].gain});
      rd_chk("status", REG_AGC_STATUS, {3'h0, rows[i].gain});
    end
    wr(REG_ATTACK, 8'h02);
    wr(REG_RELEASE, 8'h01);
    rd_chk("attack", REG_ATTACK, 8'h02);
    rd_chk("release", REG_RELEASE, 8'h01);
    wr(REG_FIXED_GAIN, 8'h14);
    repeat (400) @(negedge clk);
    // Foreign address must leave the device untouched
    host.dev7 = 7'h41;
    host.reg_write(REG_FIXED_GAIN, 8'h03, ok);
    host.dev7 = 7'h40;
    check("foreign ack", {15'h0, ok}, 16'h0000);
    check("foreign gain", {11'h0, amp_gain}, 16'h0014);
    out_level = 12'd200;
    wait_step();
    wait_step();
    check("attack interval", 16'(cyc), 16'd10);
    check("attack gain", {11'h0, amp_gain}, 16'h0012);
    out_level = 12'd100;
    repeat (40) @(negedge clk);
    check("at limit", {11'h0, amp_gain}, 16'h0012);
    out_level = 12'd50;
    wait_step();
    wait_step();
    check("release interval", 16'(cyc), 16'd13);
    check("release gain", {11'h0, amp_gain}, 16'h0014);
    repeat (60) @(negedge clk);
    check("gain cap", {11'h0, amp_gain}, 16'h0014);
    probe("low battery", 8'h00, 12'd0, 1'b0);
    probe("boost equal", 8'hff, 12'd100, 1'b0);
    probe("boost over", 8'hff, 12'd101, 1'b1);
    probe("slope equal", 8'h70, 12'd81, 1'b0);
    probe("slope over", 8'h70, 12'd82, 1'b1);
    out_level = 12'd0;
    wr(REG_SLOPE, 8'h10);
    probe("steep equal", 8'h70, 12'd72, 1'b0);
    probe("steep over", 8'h70, 12'd73, 1'b1);
    // Inflection below the battery hands the limit back to the boost level
    out_level = 12'd0;
    wr(REG_INFLECTION, 8'h60);
    rd_chk("inflection", REG_INFLECTION, 8'h60);
    probe("infl equal", 8'h70, 12'd100, 1'b0);
    probe("infl over", 8'h70, 12'd101, 1'b1);
    // Reset in mid-run returns every setting
    out_level = 12'd0;
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    check("rerun gain", {11'h0, amp_gain}, {11'h0, RST_FIXED_GAIN});
    check("rerun slew", {13'h0, switching_slew_control}, 16'h0000);
    check("rerun sample", amp_sample, 16'h0000);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    rd_chk("inflection", REG_INFLECTION, RST_INFLECTION);
    rd_chk("slope", REG_SLOPE, RST_SLOPE);
    final_report();
  end
endmodule
